// >>> cs_area_wait_pkg.sv
package cs_area_wait_pkg;

	// ==========================================================
	// register map
	localparam logic [7:0] WAIT_CTRL_OFFSET = 8'h00;
	localparam logic [31:0] WAIT_CTRL_RESET = 32'h0000_0500;
	localparam logic [31:0] WAIT_CTRL_WMASK = 32'h0017_1FC3;

	// ==========================================================
	// field positions
	localparam int BYTE_SEL_POS = 20;
	localparam int WRITE_WAIT_POS = 16;
	localparam int SETUP_POS = 11;
	localparam int READ_WAIT_POS = 7;
	localparam int WAIT_MASK_POS = 6;
	localparam int HOLD_POS = 0;

	// ==========================================================
	// field and counter widths
	localparam int WRITE_WAIT_W = 3;
	localparam int READ_WAIT_W = 4;
	localparam int DELAY_W = 2;
	localparam int WAIT_CNT_W = 5;
	localparam int PHASE_CNT_W = 6;

	// ==========================================================
	// timing: one half bus cycle lasts this many clk periods
	localparam int HALF_CYCLE_CLKS = 1;

	// access sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_STROBE,
		ST_HOLD
	} access_state_e;

endpackage

// >>> wait_cycle_decoder.sv
module wait_cycle_decoder (
	input wire logic [cs_area_wait_pkg::READ_WAIT_W-1:0] readWait,
	input wire logic [cs_area_wait_pkg::WRITE_WAIT_W-1:0] writeWait,
	input wire logic isWrite,
	output logic [cs_area_wait_pkg::WAIT_CNT_W-1:0] waitCycles
);
	import cs_area_wait_pkg::*;

	// ==========================================================
	// read-wait code to cycle count
	function automatic logic [WAIT_CNT_W-1:0] readCycles(
		input logic [READ_WAIT_W-1:0] code);
		case (code)
			4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: begin
				readCycles = {1'b0, code};
			end
			4'h7: readCycles = 5'h08;
			4'h8: readCycles = 5'h0A;
			4'h9: readCycles = 5'h0C;
			4'hA: readCycles = 5'h0E;
			4'hB: readCycles = 5'h12;
			4'hC: readCycles = 5'h18;
			// prohibited codes fall back to the longest setting
			default: readCycles = 5'h18;
		endcase
	endfunction

	// pick the read or write count for this access
	always_comb begin
		if (!isWrite || writeWait == 3'h0) begin
			waitCycles = readCycles(readWait);
		end else begin
			waitCycles = {2'b00, writeWait} - 5'h01;
		end
	end

endmodule

// >>> cs_area_wait_timing_control.sv
// Decided for this implementation: the strobed register port and the register offsets.
module cs_area_wait_timing_control (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdData,
	input wire logic accReq,
	input wire logic accWrite,
	input wire logic accByteSram,
	input wire logic extWaitN,
	output logic accBusy,
	output logic accDone,
	output logic chipSelectN,
	output logic readStrobeN,
	output logic writeStrobeN,
	output logic rdWrN
);
	import cs_area_wait_pkg::*;

	// ==========================================================
	// register file
	logic [31:0] ctrl_reg, ctrl_next;
	logic [31:0] rdData_reg, rdData_next;

	// keep only writable bits, decode reads
	always_comb begin
		ctrl_next = ctrl_reg;
		rdData_next = 32'h0000_0000;
		if (regWrite && regAddr == WAIT_CTRL_OFFSET) begin
			ctrl_next = regWrData & WAIT_CTRL_WMASK;
		end
		if (regRead && regAddr == WAIT_CTRL_OFFSET) begin
			rdData_next = ctrl_reg & WAIT_CTRL_WMASK;
		end
	end

	// register state
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_reg <= WAIT_CTRL_RESET;
			rdData_reg <= 32'h0000_0000;
		end else begin
			ctrl_reg <= ctrl_next;
			rdData_reg <= rdData_next;
		end
	end

	assign regRdData = rdData_reg;

	// ==========================================================
	// access sequencer
	access_state_e state_reg, state_next;
	logic [PHASE_CNT_W-1:0] cnt_reg, cnt_next;
	logic write_reg, write_next;
	logic byteSram_reg, byteSram_next;
	logic byteSel_reg, byteSel_next;
	logic mask_reg, mask_next;
	logic [DELAY_W-1:0] setup_reg, setup_next;
	logic [DELAY_W-1:0] hold_reg, hold_next;
	logic [READ_WAIT_W-1:0] rwait_reg, rwait_next;
	logic [WRITE_WAIT_W-1:0] wwait_reg, wwait_next;
	logic [WAIT_CNT_W-1:0] waitCycles;
	logic done_next;

	// wait count for the latched access
	wait_cycle_decoder u_decoder (
		.readWait(rwait_reg),
		.writeWait(wwait_reg),
		.isWrite(write_reg),
		.waitCycles(waitCycles)
	);

	// half-cycle phase lengths minus one, in clk periods
	function automatic logic [PHASE_CNT_W-1:0] delayLoad(
		input logic [DELAY_W-1:0] code);
		delayLoad = PHASE_CNT_W'({code, 1'b0} * HALF_CYCLE_CLKS);
	endfunction

	// next state of the sequencer and latched settings
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		write_next = write_reg;
		byteSram_next = byteSram_reg;
		byteSel_next = byteSel_reg;
		mask_next = mask_reg;
		setup_next = setup_reg;
		hold_next = hold_reg;
		rwait_next = rwait_reg;
		wwait_next = wwait_reg;
		done_next = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				if (accReq) begin
					write_next = accWrite;
					byteSram_next = accByteSram;
					byteSel_next = ctrl_reg[BYTE_SEL_POS];
					mask_next = ctrl_reg[WAIT_MASK_POS];
					setup_next = ctrl_reg[SETUP_POS +: DELAY_W];
					hold_next = ctrl_reg[HOLD_POS +: DELAY_W];
					rwait_next = ctrl_reg[READ_WAIT_POS +: READ_WAIT_W];
					wwait_next = ctrl_reg[WRITE_WAIT_POS +: WRITE_WAIT_W];
					// set-up lasts 2*code+1 half cycles
					cnt_next = delayLoad(ctrl_reg[SETUP_POS +: DELAY_W]);
					state_next = ST_SETUP;
				end
			end
			ST_SETUP: begin
				if (cnt_reg == '0) begin
					// strobe lasts one bus cycle plus the wait cycles
					cnt_next = {waitCycles, 1'b0} + 6'h01;
					state_next = ST_STROBE;
				end else begin
					cnt_next = cnt_reg - 6'h01;
				end
			end
			ST_STROBE: begin
				if (cnt_reg != '0) begin
					cnt_next = cnt_reg - 6'h01;
				end else if (!mask_reg && !extWaitN) begin
					cnt_next = cnt_reg;
				end else begin
					cnt_next = delayLoad(hold_reg);
					state_next = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (cnt_reg == '0) begin
					done_next = 1'b1;
					state_next = ST_IDLE;
				end else begin
					cnt_next = cnt_reg - 6'h01;
				end
			end
			default: begin
				state_next = ST_IDLE;
				cnt_next = '0;
			end
		endcase
	end

	// ==========================================================
	// pin values, derived from the next state so pins stay flopped
	logic csN_next, rdN_next, weN_next, rwN_next;
	logic inAccess, inStrobe;

	always_comb begin
		inAccess = state_next != ST_IDLE;
		inStrobe = state_next == ST_STROBE;
		csN_next = !inAccess;
		rdN_next = !(inStrobe && !write_next);
		rwN_next = 1'b1;
		weN_next = 1'b1;
		if (write_next) begin
			weN_next = !inStrobe;
			if (byteSram_next && byteSel_next) begin
				rwN_next = !inStrobe;
			end else begin
				rwN_next = !inAccess;
			end
		end else if (byteSram_next) begin
			if (byteSel_next) begin
				weN_next = !inAccess;
			end else begin
				weN_next = !inStrobe;
			end
		end
	end

	// sequencer and pin registers
	logic csN_reg, rdN_reg, weN_reg, rwN_reg, busy_reg, done_reg;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_IDLE;
			cnt_reg <= '0;
			write_reg <= 1'b0;
			byteSram_reg <= 1'b0;
			byteSel_reg <= 1'b0;
			mask_reg <= 1'b0;
			setup_reg <= '0;
			hold_reg <= '0;
			rwait_reg <= '0;
			wwait_reg <= '0;
			csN_reg <= 1'b1;
			rdN_reg <= 1'b1;
			weN_reg <= 1'b1;
			rwN_reg <= 1'b1;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			write_reg <= write_next;
			byteSram_reg <= byteSram_next;
			byteSel_reg <= byteSel_next;
			mask_reg <= mask_next;
			setup_reg <= setup_next;
			hold_reg <= hold_next;
			rwait_reg <= rwait_next;
			wwait_reg <= wwait_next;
			csN_reg <= csN_next;
			rdN_reg <= rdN_next;
			weN_reg <= weN_next;
			rwN_reg <= rwN_next;
			busy_reg <= inAccess;
			done_reg <= done_next;
		end
	end

	assign chipSelectN = csN_reg;
	assign readStrobeN = rdN_reg;
	assign writeStrobeN = weN_reg;
	assign rdWrN = rwN_reg;
	assign accBusy = busy_reg;
	assign accDone = done_reg;

	// ==========================================================
	// checking helpers: phase lengths in clk periods
	logic [7:0] setupLen, strobeLen, holdLen;

	// count cycles spent in each phase
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			setupLen <= 8'h00;
			strobeLen <= 8'h00;
			holdLen <= 8'h00;
		end else begin
			setupLen <= (state_reg == ST_SETUP) ? setupLen + 8'h01 : 8'h00;
			strobeLen <= (state_reg == ST_STROBE) ? strobeLen + 8'h01 : 8'h00;
			holdLen <= (state_reg == ST_HOLD) ? holdLen + 8'h01 : 8'h00;
		end
	end

	// wait cycles each read-wait code from 0 to C stands for, kept apart from the decoder
	function automatic logic [7:0] ruleWaits(input logic [3:0] code);
		case (code)
			4'h7: ruleWaits = 8'h08;
			4'h8: ruleWaits = 8'h0A;
			4'h9: ruleWaits = 8'h0C;
			4'hA: ruleWaits = 8'h0E;
			4'hB: ruleWaits = 8'h12;
			4'hC: ruleWaits = 8'h18;
			default: ruleWaits = {4'h0, code};
		endcase
	endfunction

	// ==========================================================
	// assertions
	a_reserved_zero: assert property (
		@(posedge clk) disable iff (!arst_n)
		(rdData_reg & ~WAIT_CTRL_WMASK) == 32'h0000_0000)
	else $error("reserved bits read non-zero");

	a_setup_delay: assert property (
		@(posedge clk) disable iff (!arst_n)
		(state_reg == ST_STROBE && $past(state_reg) == ST_SETUP) |->
		setupLen == {5'h00, setup_reg, 1'b1})
	else $error("strobe set-up delay wrong");

	a_hold_delay: assert property (
		@(posedge clk) disable iff (!arst_n)
		$rose(chipSelectN) |-> holdLen == {5'h00, hold_reg, 1'b1})
	else $error("chip-select hold delay wrong");

	a_read_wait: assert property (
		@(posedge clk) disable iff (!arst_n)
		(state_reg == ST_HOLD && $past(state_reg) == ST_STROBE &&
		!write_reg && mask_reg) |->
		strobeLen == 8'(2 * ruleWaits(rwait_reg) + 2))
	else $error("read wait count wrong");

	a_write_wait: assert property (
		@(posedge clk) disable iff (!arst_n)
		(state_reg == ST_HOLD && $past(state_reg) == ST_STROBE &&
		write_reg && mask_reg && wwait_reg != 3'h0) |->
		strobeLen == {4'h0, wwait_reg, 1'b0})
	else $error("write wait count wrong");

	a_write_same: assert property (
		@(posedge clk) disable iff (!arst_n)
		(state_reg == ST_HOLD && $past(state_reg) == ST_STROBE &&
		write_reg && mask_reg && wwait_reg == 3'h0) |->
		strobeLen == 8'(2 * ruleWaits(rwait_reg) + 2))
	else $error("write wait does not follow read wait");

	a_wait_stretch: assert property (
		@(posedge clk) disable iff (!arst_n)
		(state_reg == ST_STROBE && cnt_reg == '0 && !mask_reg &&
		!extWaitN) |=> state_reg == ST_STROBE && !chipSelectN)
	else $error("external wait did not stretch strobe");

	a_wait_masked: assert property (
		@(posedge clk) disable iff (!arst_n)
		(state_reg == ST_STROBE && cnt_reg == '0 && mask_reg) |=>
		state_reg == ST_HOLD)
	else $error("masked wait still stretched access");

	a_bas0_write: assert property (
		@(posedge clk) disable iff (!arst_n)
		(state_reg != ST_IDLE && write_reg && byteSram_reg &&
		!byteSel_reg) |-> !rdWrN && (writeStrobeN == (state_reg != ST_STROBE)))
	else $error("byte write direction or strobe wrong");

	a_bas1_read: assert property (
		@(posedge clk) disable iff (!arst_n)
		(state_reg != ST_IDLE && !write_reg && byteSram_reg &&
		byteSel_reg) |-> !writeStrobeN && rdWrN)
	else $error("byte read strobe not held");

endmodule

// >>> sram_partner.sv
module sram_partner (
	input wire logic clk,
	input wire logic chipSelectN,
	input wire logic readStrobeN,
	input wire logic writeStrobeN,
	input wire logic [3:0] waitLen,
	output logic extWaitN
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	logic waitN = 1'b1;
	// ==========================================================
	// slow memory: holds wait low for waitLen-1 clk after a strobe
	// wait line is driven high while not selected or while no strobe is low
	always @(posedge clk) begin
		if (chipSelectN || (readStrobeN && writeStrobeN)) begin
			cnt <= 0;
			waitN <= 1'b1;
		end else begin
			cnt <= cnt + 1;
			waitN <= (cnt + 1 >= waitLen);
		end
	end
	assign extWaitN = waitN;
endmodule

// >>> cs_area_wait_timing_control_bench.sv
`define CHK(nm, exp, got) \
	begin \
		checked++; \
		if ((got) !== (exp)) begin \
			errors++; \
			$display("BAD %s exp %0h got %0h", nm, exp, got); \
		end \
	end

module cs_area_wait_timing_control_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import cs_area_wait_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0000_0000;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [31:0] regRdData;
	logic accReq = 1'b0;
	logic accWrite = 1'b0;
	logic accByteSram = 1'b0;
	logic extWaitN;
	logic accBusy;
	logic accDone;
	logic chipSelectN;
	logic readStrobeN;
	logic writeStrobeN;
	logic rdWrN;
	logic [3:0] waitLen = 4'h0;
	logic [31:0] rdv;
	int errors = 0;
	int checked = 0;
	int n, weLow, dirLow, first, csLow, busyHi;
	int waitTab [13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24};

	// ==========================================================
	// design and memory model
	cs_area_wait_timing_control DUT (.clk(clk), .arst_n(arst_n),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
		.regRead(regRead), .regRdData(regRdData), .accReq(accReq),
		.accWrite(accWrite), .accByteSram(accByteSram),
		.extWaitN(extWaitN), .accBusy(accBusy), .accDone(accDone),
		.chipSelectN(chipSelectN), .readStrobeN(readStrobeN),
		.writeStrobeN(writeStrobeN), .rdWrN(rdWrN));
	sram_partner mem (.clk(clk), .chipSelectN(chipSelectN),
		.readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN),
		.waitLen(waitLen), .extWaitN(extWaitN));

	// clock, 40 ns period
	always #20 clk = ~clk;

	// ==========================================================
	// bus tasks
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask

	// read data sampled in the cycle after the strobe
	task rd(input logic [7:0] a);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1 rdv = regRdData;
	endtask

	task cfg(input logic byte_access_select, input logic [2:0] ww, input logic [1:0] sw,
		input logic [3:0] rw, input logic wm, input logic [1:0] hw);
		wr(8'h00, {11'h000, byte_access_select, 1'b0, ww, 3'h0, sw, rw, wm, 4'h0, hw});
	endtask

	// runs one access, counts cycles up to the done pulse
	task acc(input logic w, input logic b, input int expN, input int expF);
		@(posedge clk);
		accReq <= 1'b1;
		accWrite <= w;
		accByteSram <= b;
		@(posedge clk);
		accReq <= 1'b0;
		n = 0;
		weLow = 0;
		dirLow = 0;
		first = 0;
		csLow = 0;
		busyHi = 0;
		while (n < 200) begin
			#1;
			n++;
			if (chipSelectN === 1'b0) csLow++;
			if (accBusy === 1'b1) busyHi++;
			if (writeStrobeN === 1'b0) weLow++;
			if (rdWrN === 1'b0) dirLow++;
			if (first == 0 && (w ? writeStrobeN : readStrobeN) === 1'b0)
				first = n;
			if (accDone === 1'b1) break;
			@(posedge clk);
		end
		if (expN > 0) `CHK("total", expN, n)
		if (expF > 0) `CHK("setup", expF, first)
		`CHK("done", 1'b1, accDone)
		`CHK("cs", n - 1, csLow)
		`CHK("busy", n - 1, busyHi)
	endtask

	// expected cycles from the taking edge to the done pulse
	function automatic int tot(input int sw, input int w, input int hw);
		return 2 * sw + 1 + 2 * w + 2 + 2 * hw + 1 + 1;
	endfunction

	task end_sim;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ==========================================================
	// watchdog
	initial begin
		#(10000 * 40);
		errors++;
		end_sim;
	end

	// ==========================================================
	// tests
	initial begin
		int w;
		int k;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		rd(8'h00);
		`CHK("reset", WAIT_CTRL_RESET, rdv)
		// all fields set, reserved bits zero, read-wait code 1100
		wr(8'h00, 32'h0017_1E43);
		rd(8'h00);
		`CHK("rsvd", 32'h0017_1E43, rdv)
		wr(8'h04, 32'h0000_0000);
		rd(8'h04);
		`CHK("unmapped", 32'h0000_0000, rdv)
		rd(8'h00);
		`CHK("kept", 32'h0017_1E43, rdv)
		$display("test registers done");
		for (int i = 0; i < 13; i++) begin
			cfg(0, 3'h0, 2'h0, i[3:0], 1, 2'h0);
			acc(0, 0, tot(0, waitTab[i], 0), 2);
		end
		$display("test read waits done");
		for (int i = 0; i < 8; i++) begin
			cfg(0, i[2:0], 2'h0, 4'h5, 1, 2'h0);
			w = (i == 0) ? 5 : i - 1;
			acc(1, 0, tot(0, w, 0), 2);
		end
		$display("test write waits done");
		for (int i = 0; i < 4; i++) begin
			cfg(0, 3'h1, i[1:0], 4'h0, 1, 2'(3 - i));
			acc(0, 0, tot(i, 0, 3 - i), 2 * i + 2);
			acc(1, 0, tot(i, 0, 3 - i), 2 * i + 2);
		end
		$display("test setup hold done");
		k = tot(0, 1, 0) - 1;
		for (int i = 0; i < 4; i++) begin
			cfg(i[1], 3'h0, 2'h0, 4'h1, 1, 2'h0);
			acc(i[0], 1, tot(0, 1, 0), i[0] ? 2 : 0);
			`CHK("byteWe", (i == 2) ? k : 4, weLow)
			`CHK("byteDir", i[0] ? ((i == 1) ? k : 4) : 0, dirLow)
		end
		$display("test byte sram done");
		cfg(0, 3'h0, 2'h0, 4'h0, 1, 2'h0);
		waitLen <= 4'h6;
		acc(0, 0, tot(0, 0, 0), 2);
		cfg(0, 3'h0, 2'h0, 4'h0, 0, 2'h0);
		acc(0, 0, 0, 2);
		// wait is seen low on waitLen-1 edges once the strobe count is out
		`CHK("stretch", tot(0, 0, 0) + 6 - 1, n)
		cfg(0, 3'h0, 2'h0, 4'h3, 0, 2'h0);
		waitLen <= 4'h3;
		acc(0, 0, tot(0, 3, 0), 2);
		$display("test external wait done");
		end_sim;
	end
endmodule
